// ===== pkg/eos_pkg.sv
package eos_pkg;

   typedef logic [1:0] eos_fmt_t;
   typedef logic [8:0] eos_div_t;
   typedef logic [9:0] eos_acc_t;

   // Output and external input signal formats
   localparam eos_fmt_t FMT_STEP_DIR = 2'h0;
   localparam eos_fmt_t FMT_UP_DOWN  = 2'h1;
   localparam eos_fmt_t FMT_QUAD     = 2'h2;

   // Divisor range accepted by the set and gate commands
   localparam eos_div_t DIV_MIN = 9'h001;
   localparam eos_div_t DIV_MAX = 9'h100;

   // Encoder counts per output step pulse at a divisor of one
   localparam int STEP_COUNTS_PER_PULSE = 2;

   // Clock and step pulse timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int PULSE_HIGH_NS  = 200;
   localparam int PULSE_LOW_NS   = 200;
   localparam int PULSE_HIGH_CYC = (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_LOW_CYC  = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset values of the control state
   localparam logic     RAW_MON_RST = 1'b0;
   localparam logic     DIV_EN_RST  = 1'b0;
   localparam logic     GATE_RST    = 1'b0;
   localparam logic     FB_EXT_RST  = 1'b0;
   localparam eos_div_t DIV_N_RST   = 9'h001;
   localparam eos_fmt_t FMT_RST     = 2'h2;

   typedef enum logic [1:0] {PS_IDLE, PS_HIGH, PS_LOW} eos_pulse_e;

   function automatic eos_acc_t eos_thresh(input eos_div_t div, input eos_fmt_t fmt);
      if (fmt == FMT_QUAD)
         return {1'b0, div};
      else
         return eos_acc_t'(STEP_COUNTS_PER_PULSE * int'(div));
   endfunction : eos_thresh

endpackage : eos_pkg

// ===== pkg/eos_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eos_cnt_if;
   logic cnt_en;
   logic cnt_up;
   modport src (output cnt_en, output cnt_up);
   modport snk (input cnt_en, input cnt_up);
endinterface : eos_cnt_if
`default_nettype wire

// ===== core/eos_edge_decode.sv
`timescale 1ns/1ps
`default_nettype none
module eos_edge_decode
   import eos_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              line_a_i,
   input  wire logic              line_b_i,
   input  wire eos_pkg::eos_fmt_t fmt_i,
   eos_cnt_if.src                 cnt
);

   logic [1:0] prev_q;
   logic [1:0] prev_d;
   logic       en_q;
   logic       en_d;
   logic       up_q;
   logic       up_d;
   logic       rise_a;
   logic       rise_b;

   always_comb
   begin
      prev_d = {line_b_i, line_a_i};
      rise_a = line_a_i & ~prev_q[0];
      rise_b = line_b_i & ~prev_q[1];
      case (fmt_i)
         FMT_STEP_DIR:
         begin
            en_d = rise_a;
            up_d = line_b_i;
         end
         FMT_UP_DOWN:
         begin
            // Simultaneous up and down steps cancel out
            en_d = rise_a ^ rise_b;
            up_d = rise_a;
         end
         default:
         begin
            // Both phases moving at once is illegal and counts nothing
            en_d = (line_a_i ^ prev_q[0]) ^ (line_b_i ^ prev_q[1]);
            up_d = line_a_i ^ prev_q[1];
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prev_q <= 2'h0;
         en_q   <= 1'b0;
         up_q   <= 1'b0;
      end
      else
      begin
         prev_q <= prev_d;
         en_q   <= en_d;
         up_q   <= up_d;
      end
   end

   assign cnt.cnt_en = en_q;
   assign cnt.cnt_up = up_q;

   AST_QUAD_FWD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (fmt_i == FMT_QUAD && prev_q == 2'h0 && line_a_i && !line_b_i) |=> (en_q && up_q))
      else $error("Leading phase A edge not decoded as forward count");

   AST_STEP_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (fmt_i == FMT_STEP_DIR && $rose(line_a_i)) |-> ##1 (en_q && up_q == $past(line_b_i)))
      else $error("Step edge not counted with direction level");

endmodule : eos_edge_decode
`default_nettype wire

// ===== core/eos_top.sv
// Function
// - Raw monitor drives internal phase A, B and index on I/O lines 1, 2, 3.
// - Raw monitor is an unscaled buffered quadrature copy, no other format.
// - Monitor-on command enables raw output only if lines 1 to 3 are all inputs, else flags an error; monitor-off command disables it.
// - Divided output only divides the count rate, never multiplies it.
// - Divisor accepts any integer from 1 through 256.
// - Step formats at divisor one give one pulse per two counts.
// - Quadrature at divisor one gives one full cycle per four counts.
// - Divisor N above one reduces the output rate by N.
// - Set command enables the divided output and starts it on lines 6 and 7.
// - Set command carries divisor, one of three formats and count source.
// - Triggered mode uses the I/O line 1 level to start and stop output.
// - Clear command disables divided output and releases lines 6 and 7.
// - External source selection derives divided output from external counts.
// - Dual-loop uses external counts for position, internal for commutation.
// - Single-loop command returns to internal encoder for all purposes.
// - External input accepts step-direction, up-down and quadrature formats.
// - Step-direction: each rising step edge one count, direction level selects sense.
// - Up-down: one line counts forward, the other counts reverse.
// - Quadrature: every edge of either phase counts, leading phase gives direction.
`timescale 1ns/1ps
`default_nettype none
module eos_top
   import eos_pkg::*;
(
   input  wire logic              REF_CLK_I,
   input  wire logic              ARST_N_I,
   input  wire logic              ENC_A_I,
   input  wire logic              ENC_B_I,
   input  wire logic              ENC_INDEX_I,
   input  wire logic              EXT_A_I,
   input  wire logic              EXT_B_I,
   input  wire eos_pkg::eos_fmt_t EXT_FORMAT_I,
   input  wire logic              IO1_I,
   input  wire logic [2:0]        IO_LOW_IS_INPUT_I,
   input  wire logic              RAW_MONITOR_ON_CMD_I,
   input  wire logic              RAW_MONITOR_OFF_CMD_I,
   input  wire logic              DIVIDED_OUTPUT_SET_CMD_I,
   input  wire logic              DIVIDED_OUTPUT_GATE_CMD_I,
   input  wire logic              DIVIDED_OUTPUT_CLEAR_CMD_I,
   input  wire eos_pkg::eos_div_t DIVISOR_I,
   input  wire eos_pkg::eos_fmt_t OUT_FORMAT_I,
   input  wire logic              SOURCE_EXT_I,
   input  wire logic              EXTERNAL_FEEDBACK_CMD_I,
   input  wire logic              INTERNAL_FEEDBACK_CMD_I,
   output logic                   IO1_O,
   output logic                   IO1_OE_N_O,
   output logic                   IO2_O,
   output logic                   IO2_OE_N_O,
   output logic                   IO3_O,
   output logic                   IO3_OE_N_O,
   output logic                   IO6_O,
   output logic                   IO6_OE_N_O,
   output logic                   IO7_O,
   output logic                   IO7_OE_N_O,
   output logic                   RAW_MONITOR_EN_O,
   output logic                   MONITOR_ERR_O,
   output logic                   DIVIDED_EN_O,
   output logic                   GATED_O,
   output logic                   FB_EXT_SEL_O,
   output logic                   FB_CNT_EN_O,
   output logic                   FB_CNT_UP_O,
   output logic                   COMM_CNT_EN_O,
   output logic                   COMM_CNT_UP_O
);

   localparam logic [2:0] PULSE_HIGH_W = 3'(PULSE_HIGH_CYC);
   localparam logic [2:0] PULSE_LOW_W  = 3'(PULSE_LOW_CYC);

   // Pin synchroniser: int A, int B, index, ext A, ext B, I/O line 1
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic       enc_a_s;
   logic       enc_b_s;
   logic       enc_idx_s;
   logic       ext_a_s;
   logic       ext_b_s;
   logic       io1_s;

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end
      else
      begin
         sync1_q <= {IO1_I, EXT_B_I, EXT_A_I, ENC_INDEX_I, ENC_B_I, ENC_A_I};
         sync2_q <= sync1_q;
      end
   end

   assign enc_a_s   = sync2_q[0];
   assign enc_b_s   = sync2_q[1];
   assign enc_idx_s = sync2_q[2];
   assign ext_a_s   = sync2_q[3];
   assign ext_b_s   = sync2_q[4];
   assign io1_s     = sync2_q[5];

   eos_cnt_if int_cnt ();
   eos_cnt_if ext_cnt ();

   eos_edge_decode u_int_dec (
      .clk_i    (REF_CLK_I),
      .rst_n_i  (ARST_N_I),
      .line_a_i (enc_a_s),
      .line_b_i (enc_b_s),
      .fmt_i    (FMT_QUAD),
      .cnt      (int_cnt.src)
   );

   eos_edge_decode u_ext_dec (
      .clk_i    (REF_CLK_I),
      .rst_n_i  (ARST_N_I),
      .line_a_i (ext_a_s),
      .line_b_i (ext_b_s),
      .fmt_i    (EXT_FORMAT_I),
      .cnt      (ext_cnt.src)
   );

   // Command state
   logic     raw_mon_q;
   logic     raw_mon_d;
   logic     mon_err_q;
   logic     mon_err_d;
   logic     div_en_q;
   logic     div_en_d;
   logic     gate_q;
   logic     gate_d;
   logic     src_ext_q;
   logic     src_ext_d;
   logic     fb_ext_q;
   logic     fb_ext_d;
   eos_div_t div_n_q;
   eos_div_t div_n_d;
   eos_fmt_t fmt_q;
   eos_fmt_t fmt_d;
   logic     cfg_ok;
   logic     load_ok;

   assign cfg_ok  = (DIVISOR_I >= DIV_MIN) && (DIVISOR_I <= DIV_MAX) && (OUT_FORMAT_I != 2'h3);
   assign load_ok = (DIVIDED_OUTPUT_SET_CMD_I || DIVIDED_OUTPUT_GATE_CMD_I) && cfg_ok
                    && !DIVIDED_OUTPUT_CLEAR_CMD_I;

   always_comb
   begin
      raw_mon_d = raw_mon_q;
      mon_err_d = mon_err_q;
      div_en_d  = div_en_q;
      gate_d    = gate_q;
      src_ext_d = src_ext_q;
      fb_ext_d  = fb_ext_q;
      div_n_d   = div_n_q;
      fmt_d     = fmt_q;
      if (RAW_MONITOR_OFF_CMD_I)
      begin
         raw_mon_d = 1'b0;
         mon_err_d = 1'b0;
      end
      else if (RAW_MONITOR_ON_CMD_I)
      begin
         // Driving lines still set as outputs would fight them
         if (&IO_LOW_IS_INPUT_I)
         begin
            raw_mon_d = 1'b1;
            mon_err_d = 1'b0;
         end
         else
            mon_err_d = 1'b1;
      end
      if (DIVIDED_OUTPUT_CLEAR_CMD_I)
      begin
         div_en_d = 1'b0;
         gate_d   = 1'b0;
      end
      else if (load_ok)
      begin
         div_en_d  = 1'b1;
         gate_d    = DIVIDED_OUTPUT_GATE_CMD_I;
         div_n_d   = DIVISOR_I;
         fmt_d     = OUT_FORMAT_I;
         src_ext_d = SOURCE_EXT_I;
      end
      if (INTERNAL_FEEDBACK_CMD_I)
         fb_ext_d = 1'b0;
      else if (EXTERNAL_FEEDBACK_CMD_I)
         fb_ext_d = 1'b1;
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         raw_mon_q <= RAW_MON_RST;
         mon_err_q <= 1'b0;
         div_en_q  <= DIV_EN_RST;
         gate_q    <= GATE_RST;
         src_ext_q <= 1'b0;
         fb_ext_q  <= FB_EXT_RST;
         div_n_q   <= DIV_N_RST;
         fmt_q     <= FMT_RST;
      end
      else
      begin
         raw_mon_q <= raw_mon_d;
         mon_err_q <= mon_err_d;
         div_en_q  <= div_en_d;
         gate_q    <= gate_d;
         src_ext_q <= src_ext_d;
         fb_ext_q  <= fb_ext_d;
         div_n_q   <= div_n_d;
         fmt_q     <= fmt_d;
      end
   end

   // Divider and output generation
   logic       src_en;
   logic       src_up;
   logic       run;
   eos_acc_t   thresh;
   eos_acc_t   acc_q;
   eos_acc_t   acc_d;
   logic       emit;
   logic       emit_up;
   logic [1:0] quad_q;
   logic [1:0] quad_d;
   eos_pulse_e pstate_q;
   eos_pulse_e pstate_d;
   logic [2:0] pcnt_q;
   logic [2:0] pcnt_d;
   logic       dir_q;
   logic       dir_d;
   logic       pulse_start;

   assign src_en = src_ext_q ? ext_cnt.cnt_en : int_cnt.cnt_en;
   assign src_up = src_ext_q ? ext_cnt.cnt_up : int_cnt.cnt_up;
   assign run    = div_en_q && (!gate_q || io1_s);
   assign thresh = eos_thresh(div_n_q, fmt_q);

   always_comb
   begin
      acc_d    = acc_q;
      emit     = 1'b0;
      emit_up  = src_up;
      quad_d   = quad_q;
      pstate_d = pstate_q;
      pcnt_d   = pcnt_q;
      dir_d    = dir_q;
      pulse_start = 1'b0;
      // Modulo counter in [0, thresh) moves both ways, so a reversal
      // retraces the same edge instead of drifting
      if (div_en_q && src_en)
      begin
         if (src_up)
         begin
            if (acc_q == thresh - 10'h001)
            begin
               acc_d = 10'h000;
               emit  = 1'b1;
            end
            else
               acc_d = acc_q + 10'h001;
         end
         else if (acc_q == 10'h000)
         begin
            acc_d = thresh - 10'h001;
            emit  = 1'b1;
         end
         else
            acc_d = acc_q - 10'h001;
      end
      if (fmt_q == FMT_QUAD)
      begin
         if (emit && run)
            quad_d = emit_up ? quad_q + 2'h1 : quad_q - 2'h1;
      end
      // Step pulses are not queued: a step request while a pulse is in
      // flight is lost, which bounds the divided rate to one per 11 cycles
      case (pstate_q)
         PS_IDLE:
         begin
            if (emit && run && fmt_q != FMT_QUAD)
            begin
               pulse_start = 1'b1;
               dir_d       = emit_up;
               pstate_d    = PS_HIGH;
               pcnt_d      = PULSE_HIGH_W - 3'h1;
            end
         end
         PS_HIGH:
         begin
            if (pcnt_q == 3'h0)
            begin
               pstate_d = PS_LOW;
               pcnt_d   = PULSE_LOW_W - 3'h1;
            end
            else
               pcnt_d = pcnt_q - 3'h1;
         end
         PS_LOW:
         begin
            if (pcnt_q == 3'h0)
               pstate_d = PS_IDLE;
            else
               pcnt_d = pcnt_q - 3'h1;
         end
         default:
            pstate_d = PS_IDLE;
      endcase
      if (!div_en_q)
      begin
         acc_d    = 10'h000;
         quad_d   = 2'h0;
         pstate_d = PS_IDLE;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         acc_q    <= 10'h000;
         quad_q   <= 2'h0;
         pstate_q <= PS_IDLE;
         pcnt_q   <= 3'h0;
         dir_q    <= 1'b0;
      end
      else
      begin
         acc_q    <= acc_d;
         quad_q   <= quad_d;
         pstate_q <= pstate_d;
         pcnt_q   <= pcnt_d;
         dir_q    <= dir_d;
      end
   end

   // Registered pin and status outputs
   logic [2:0] mon_q;
   logic [2:0] mon_d;
   logic       line6_q;
   logic       line6_d;
   logic       line7_q;
   logic       line7_d;
   logic [3:0] cnt_out_q;
   logic [3:0] cnt_out_d;
   logic       step_hi;

   assign step_hi = (pstate_d == PS_HIGH);

   always_comb
   begin
      mon_d = {enc_idx_s, enc_b_s, enc_a_s};
      case (fmt_q)
         FMT_STEP_DIR:
         begin
            line6_d = step_hi;
            line7_d = dir_d;
         end
         FMT_UP_DOWN:
         begin
            line6_d = step_hi && dir_d;
            line7_d = step_hi && !dir_d;
         end
         default:
         begin
            line6_d = quad_d[1] ^ quad_d[0];
            line7_d = quad_d[1];
         end
      endcase
      cnt_out_d = {int_cnt.cnt_up, int_cnt.cnt_en,
                   fb_ext_q ? ext_cnt.cnt_up : int_cnt.cnt_up,
                   fb_ext_q ? ext_cnt.cnt_en : int_cnt.cnt_en};
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         mon_q     <= 3'h0;
         line6_q   <= 1'b0;
         line7_q   <= 1'b0;
         cnt_out_q <= 4'h0;
      end
      else
      begin
         mon_q     <= mon_d;
         line6_q   <= line6_d;
         line7_q   <= line7_d;
         cnt_out_q <= cnt_out_d;
      end
   end

   assign IO1_O            = mon_q[0];
   assign IO2_O            = mon_q[1];
   assign IO3_O            = mon_q[2];
   assign IO1_OE_N_O       = !raw_mon_q;
   assign IO2_OE_N_O       = !raw_mon_q;
   assign IO3_OE_N_O       = !raw_mon_q;
   assign IO6_O            = line6_q;
   assign IO7_O            = line7_q;
   assign IO6_OE_N_O       = !div_en_q;
   assign IO7_OE_N_O       = !div_en_q;
   assign RAW_MONITOR_EN_O = raw_mon_q;
   assign MONITOR_ERR_O    = mon_err_q;
   assign DIVIDED_EN_O     = div_en_q;
   assign GATED_O          = gate_q;
   assign FB_EXT_SEL_O     = fb_ext_q;
   assign FB_CNT_EN_O      = cnt_out_q[0];
   assign FB_CNT_UP_O      = cnt_out_q[1];
   assign COMM_CNT_EN_O    = cnt_out_q[2];
   assign COMM_CNT_UP_O    = cnt_out_q[3];

   sequence s_step_pulse;
      (pstate_q == PS_HIGH)[*5] ##1 (pstate_q == PS_LOW)[*5] ##1 (pstate_q == PS_IDLE);
   endsequence

   sequence s_up_wrap;
      div_en_q && src_en && src_up && acc_q == thresh - 10'h001;
   endsequence

   AST_RAW_COPY: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      raw_mon_q |-> (IO1_O == $past(enc_a_s) && IO2_O == $past(enc_b_s) && IO3_O == $past(enc_idx_s)))
      else $error("Raw monitor lines do not follow the internal encoder");

   AST_MON_ON: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (RAW_MONITOR_ON_CMD_I && !RAW_MONITOR_OFF_CMD_I && &IO_LOW_IS_INPUT_I)
      |=> (RAW_MONITOR_EN_O && !IO1_OE_N_O && !MONITOR_ERR_O))
      else $error("Monitor-on did not enable the raw output");

   AST_MON_ERR: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (RAW_MONITOR_ON_CMD_I && !RAW_MONITOR_OFF_CMD_I && !(&IO_LOW_IS_INPUT_I) && !raw_mon_q)
      |=> (MONITOR_ERR_O && IO1_OE_N_O))
      else $error("Monitor-on with lines not inputs did not raise error");

   AST_MON_OFF: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      RAW_MONITOR_OFF_CMD_I |=> (!RAW_MONITOR_EN_O && IO1_OE_N_O && IO3_OE_N_O))
      else $error("Monitor-off did not release lines 1 to 3");

   // Disabling zeroes the quadrature state without a count, so only enabled moves are checked
   AST_NO_MULT: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (div_en_q && (pulse_start || quad_d != quad_q)) |-> (src_en && run))
      else $error("Divided output moved without an encoder count");

   AST_DIV_RANGE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      div_en_q |-> (div_n_q >= DIV_MIN && div_n_q <= DIV_MAX))
      else $error("Divisor outside 1 to 256 while enabled");

   AST_STEP_SHAPE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (pulse_start && !DIVIDED_OUTPUT_CLEAR_CMD_I && !load_ok) |=> s_step_pulse or (##[0:9] !div_en_q))
      else $error("Step pulse does not last five high and five low cycles");

   AST_WRAP: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      s_up_wrap |-> ##1 (acc_q == 10'h000 || !div_en_q))
      else $error("Divider did not wrap at the divisor threshold");

   AST_REVERSE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (div_en_q && src_en && !src_up && acc_q == 10'h000 && !DIVIDED_OUTPUT_CLEAR_CMD_I)
      |=> (acc_q == $past(thresh) - 10'h001))
      else $error("Reverse count did not step divider back through zero");

   AST_SET: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (DIVIDED_OUTPUT_SET_CMD_I && !DIVIDED_OUTPUT_GATE_CMD_I && load_ok)
      |=> (DIVIDED_EN_O && !IO6_OE_N_O && !GATED_O && div_n_q == $past(DIVISOR_I)))
      else $error("Set command did not start the divided output");

   AST_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (div_en_q && gate_q && !io1_s && !load_ok && !DIVIDED_OUTPUT_CLEAR_CMD_I)
      |=> ($stable(quad_q) && !$rose(pstate_q == PS_HIGH)))
      else $error("Output moved while the trigger line was inactive");

   AST_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      DIVIDED_OUTPUT_CLEAR_CMD_I |=> (!DIVIDED_EN_O && IO6_OE_N_O && IO7_OE_N_O))
      else $error("Clear command did not release lines 6 and 7");

   AST_FB_EXT: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (fb_ext_q && !INTERNAL_FEEDBACK_CMD_I) |=> (FB_CNT_EN_O == $past(ext_cnt.cnt_en)
      && COMM_CNT_EN_O == $past(int_cnt.cnt_en)))
      else $error("Dual-loop feedback routing wrong");

   AST_SINGLE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      INTERNAL_FEEDBACK_CMD_I |=> !FB_EXT_SEL_O ##1 (FB_CNT_EN_O == $past(int_cnt.cnt_en)))
      else $error("Single-loop did not restore internal feedback");

endmodule : eos_top
`default_nettype wire

// ===== dv/eos_follower.sv
`timescale 1ns/1ps
`default_nettype none
module eos_follower
   import eos_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     rst_n_i,
   input  wire eos_fmt_t fmt_i,
   input  wire logic     a_i,
   input  wire logic     b_i,
   output int            pos_o
);
   logic       a_q;
   logic       b_q;
   logic [1:0] d;

   // Gray position of the pair, rising with A leading B
   function automatic logic [1:0] gidx(input logic a, input logic b);
      return {b, a ^ b};
   endfunction : gidx

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pos_o <= 0;
         // Idle lines sit at the pull-up level
         a_q <= 1'b1;
         b_q <= 1'b1;
      end
      else
      begin
         a_q <= a_i;
         b_q <= b_i;
         d = gidx(a_i, b_i) - gidx(a_q, b_q);
         if (fmt_i == FMT_STEP_DIR && a_i && !a_q)
            pos_o <= b_i ? pos_o + 1 : pos_o - 1;
         else if (fmt_i == FMT_UP_DOWN)
            pos_o <= pos_o + int'(a_i && !a_q) - int'(b_i && !b_q);
         else if (fmt_i == FMT_QUAD && d == 2'h1)
            pos_o <= pos_o + 1;
         else if (fmt_i == FMT_QUAD && d == 2'h3)
            pos_o <= pos_o - 1;
      end
   end
endmodule : eos_follower
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import eos_pkg::*;
   logic       REF_CLK_I = 1'b0, ARST_N_I = 1'b0, ENC_A_I = 1'b0, ENC_B_I = 1'b0, ENC_INDEX_I = 1'b1;
   logic       EXT_A_I = 1'b0, EXT_B_I = 1'b0, IO1_I = 1'b0, SOURCE_EXT_I = 1'b0;
   logic [6:0] cmd = '0;
   logic [2:0] IO_LOW_IS_INPUT_I = 3'h7;
   eos_fmt_t   EXT_FORMAT_I = FMT_QUAD, OUT_FORMAT_I = FMT_QUAD;
   eos_div_t   DIVISOR_I = 9'h001;
   eos_div_t   bad[2] = '{9'h000, 9'h101};
   logic       IO1_O, IO1_OE_N_O, IO2_O, IO2_OE_N_O, IO3_O, IO3_OE_N_O, IO6_O, IO6_OE_N_O, IO7_O, IO7_OE_N_O;
   logic       RAW_MONITOR_EN_O, MONITOR_ERR_O, DIVIDED_EN_O, GATED_O, FB_EXT_SEL_O;
   logic       FB_CNT_EN_O, FB_CNT_UP_O, COMM_CNT_EN_O, COMM_CNT_UP_O;
   logic [1:0] pi = 2'h0, pe = 2'h0;
   int         pos, s, c, fbn = 0, cmn = 0, mismatches = 0, n_compared = 0;
   // Released lines float to the follower's pull-up
   wire        l6 = IO6_OE_N_O ? 1'b1 : IO6_O;
   wire        l7 = IO7_OE_N_O ? 1'b1 : IO7_O;

   eos_top i_dut (.REF_CLK_I, .ARST_N_I, .ENC_A_I, .ENC_B_I, .ENC_INDEX_I, .EXT_A_I, .EXT_B_I, .EXT_FORMAT_I,
      .IO1_I, .IO_LOW_IS_INPUT_I, .RAW_MONITOR_ON_CMD_I(cmd[0]), .RAW_MONITOR_OFF_CMD_I(cmd[1]),
      .DIVIDED_OUTPUT_SET_CMD_I(cmd[2]), .DIVIDED_OUTPUT_GATE_CMD_I(cmd[3]), .DIVIDED_OUTPUT_CLEAR_CMD_I(cmd[4]),
      .DIVISOR_I, .OUT_FORMAT_I, .SOURCE_EXT_I, .EXTERNAL_FEEDBACK_CMD_I(cmd[5]), .INTERNAL_FEEDBACK_CMD_I(cmd[6]),
      .IO1_O, .IO1_OE_N_O, .IO2_O, .IO2_OE_N_O, .IO3_O, .IO3_OE_N_O, .IO6_O, .IO6_OE_N_O, .IO7_O, .IO7_OE_N_O,
      .RAW_MONITOR_EN_O, .MONITOR_ERR_O, .DIVIDED_EN_O, .GATED_O, .FB_EXT_SEL_O, .FB_CNT_EN_O, .FB_CNT_UP_O,
      .COMM_CNT_EN_O, .COMM_CNT_UP_O);
   eos_follower i_fol (.clk_i(REF_CLK_I), .rst_n_i(ARST_N_I), .fmt_i(OUT_FORMAT_I), .a_i(l6), .b_i(l7), .pos_o(pos));

   always #20 REF_CLK_I = ~REF_CLK_I;

   always @(posedge REF_CLK_I)
   begin
      // Signed tallies, so a wrong direction flag shows up as a wrong count
      fbn <= fbn + (FB_CNT_EN_O !== 1'b1 ? 0 : FB_CNT_UP_O === 1'b1 ? 1 : -1);
      cmn <= cmn + (COMM_CNT_EN_O !== 1'b1 ? 0 : COMM_CNT_UP_O === 1'b1 ? 1 : -1);
   end

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input logic g, input logic e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("FAIL %0t flag got %b exp %b", $time, g, e);
      end
   endtask : chk

   task automatic chkn(input int g, input int e);
      n_compared++;
      if (g != e)
      begin
         mismatches++;
         $display("FAIL %0t count got %0d exp %0d", $time, g, e);
      end
   endtask : chkn

   task automatic go(input int k);
      @(posedge REF_CLK_I);
      cmd[k] <= 1'b1;
      @(posedge REF_CLK_I);
      cmd <= '0;
      repeat (3) @(posedge REF_CLK_I);
   endtask : go

   // Eight cycles per count keeps step pulses from being dropped
   task automatic mv(input bit ext, input int n);
      repeat (n < 0 ? -n : n)
      begin
         @(posedge REF_CLK_I);
         if (ext)
            pe = pe + (n < 0 ? 2'h3 : 2'h1);
         else
            pi = pi + (n < 0 ? 2'h3 : 2'h1);
         EXT_A_I <= pe[0] ^ pe[1];
         EXT_B_I <= pe[1];
         ENC_A_I <= pi[0] ^ pi[1];
         ENC_B_I <= pi[1];
         ENC_INDEX_I <= pi == 2'h0;
         repeat (7) @(posedge REF_CLK_I);
      end
      repeat (20) @(posedge REF_CLK_I);
   endtask : mv

   task automatic run(input bit x, input eos_fmt_t f, input eos_div_t n, input int c1, input int c2, input int e);
      @(posedge REF_CLK_I);
      OUT_FORMAT_I <= f;
      DIVISOR_I <= n;
      SOURCE_EXT_I <= x;
      go(2);
      chk(IO6_OE_N_O, 1'b0);
      s = pos;
      mv(x, c1);
      mv(x, c2);
      chkn(pos - s, e);
      go(4);
      chk(IO7_OE_N_O, 1'b1);
   endtask : run

   initial
   begin
      repeat (40000) @(posedge REF_CLK_I);
      mismatches++;
      stop_test();
   end

   initial
   begin
      repeat (10) @(posedge REF_CLK_I);
      ARST_N_I <= 1'b1;
      chk(IO6_OE_N_O, 1'b1);
      IO_LOW_IS_INPUT_I <= 3'h3;
      go(0);
      chk(MONITOR_ERR_O, 1'b1);
      chk(RAW_MONITOR_EN_O, 1'b0);
      IO_LOW_IS_INPUT_I <= 3'h7;
      go(0);
      chk(RAW_MONITOR_EN_O, 1'b1);
      chk(IO3_OE_N_O, 1'b0);
      repeat (2)
      begin
         mv(0, 1);
         chk(IO1_O, pi[0] ^ pi[1]);
         chk(IO2_O, pi[1]);
         chk(IO3_O, pi == 2'h0);
      end
      go(1);
      chk(IO2_OE_N_O, 1'b1);
      foreach (bad[i])
      begin
         DIVISOR_I <= bad[i];
         go(2);
         chk(DIVIDED_EN_O, 1'b0);
      end
      run(0, FMT_QUAD, 9'h001, 40, 0, 40);
      run(0, FMT_STEP_DIR, 9'h001, 40, 0, 20);
      run(0, FMT_UP_DOWN, 9'h002, 40, 0, 10);
      run(0, FMT_QUAD, 9'h004, 40, 0, 10);
      run(0, FMT_STEP_DIR, 9'h001, 20, -20, 0);
      run(0, FMT_QUAD, 9'h004, 20, -20, 0);
      DIVISOR_I <= 9'h001;
      go(3);
      chk(GATED_O, 1'b1);
      s = pos;
      mv(0, 8);
      chkn(pos - s, 0);
      IO1_I <= 1'b1;
      mv(0, 0);
      s = pos;
      mv(0, 8);
      chkn(pos - s, 8);
      go(4);
      run(1, FMT_QUAD, 9'h001, 12, 0, 12);
      go(5);
      chk(FB_EXT_SEL_O, 1'b1);
      s = fbn;
      c = cmn;
      mv(1, 12);
      mv(0, 4);
      chkn(fbn - s, 12);
      chkn(cmn - c, 4);
      go(6);
      chk(FB_EXT_SEL_O, 1'b0);
      s = fbn;
      mv(0, 4);
      chkn(fbn - s, 4);
      go(5);
      EXT_A_I <= 1'b0;
      EXT_B_I <= 1'b1;
      for (int f = 0; f < 2; f++)
      begin
         EXT_FORMAT_I <= eos_fmt_t'(f);
         repeat (10) @(posedge REF_CLK_I);
         s = fbn;
         repeat (10)
         begin
            EXT_A_I <= ~EXT_A_I;
            repeat (8) @(posedge REF_CLK_I);
         end
         chkn(fbn - s, 5);
      end
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
